// ### aopmm_pkg.sv
// Purpose: shared constants and types for the adc output port mode mux
// Assumes: one 20 MHz clock; registers reached over classic Wishbone
// Notes: offsets are byte addresses of aligned 32-bit words
package aopmm_pkg;

  localparam int unsigned CLOCK_HZ       = 20_000_000;
  localparam int unsigned RESULT_W       = 18;
  localparam int unsigned PIN_W          = 7;
  localparam int unsigned ADR_W          = 4;

  localparam logic [3:0]  RESULT_OFS     = 4'h0;
  localparam logic [3:0]  STATUS_OFS     = 4'h4;
  localparam logic [3:0]  CTRL_OFS       = 4'h8;

  localparam logic [17:0] RESULT_RST     = 18'h00000;
  localparam logic        SER_EN_RST     = 1'b1;
  localparam logic        OVERRUN_RST    = 1'b0;

  localparam int unsigned CTRL_SER_EN    = 0;
  localparam int unsigned CTRL_OVR_CLR   = 1;

  localparam int unsigned ST_MODE_LSB    = 0;
  localparam int unsigned ST_CODING      = 2;
  localparam int unsigned ST_FORM_LOW    = 3;
  localparam int unsigned ST_FORM_HIGH   = 4;
  localparam int unsigned ST_DIV_LSB     = 5;
  localparam int unsigned ST_CLK_SRC     = 7;
  localparam int unsigned ST_RDC         = 8;
  localparam int unsigned ST_BUSY        = 9;
  localparam int unsigned ST_OVERRUN     = 10;

  // shortest half period of the internally made serial clock
  localparam int unsigned SCLK_HALF_NS   = 50;
  localparam int unsigned SCLK_HALF_RAW  = (SCLK_HALF_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

  typedef enum logic [1:0] {
    AOPMM_MODE_P18,
    AOPMM_MODE_P16,
    AOPMM_MODE_P8,
    AOPMM_MODE_SER
  } aopmm_mode_t;

  typedef logic [RESULT_W-1:0] aopmm_word_t;

endpackage : aopmm_pkg

// ### aopmm_ser_if.sv
// Purpose: carrier between the pin mux and its serial shifter
// Assumes: all signals on the one system clock
// Notes: sclkLvl and csActive arrive already synchronised
`timescale 1ns/1ns
interface aopmm_ser_if;
  import aopmm_pkg::*;
  logic        loadStb;
  aopmm_word_t word;
  logic        master;
  logic [1:0]  divSel;
  logic        sclkLvl;
  logic        csActive;
  logic        sdOut;
  logic        sclkDrv;
  logic        busy;

  modport ctrl  (output loadStb, word, master, divSel, sclkLvl, csActive,
                 input  sdOut, sclkDrv, busy);
  modport shift (input  loadStb, word, master, divSel, sclkLvl, csActive,
                 output sdOut, sclkDrv, busy);
endinterface : aopmm_ser_if

// ### aopmm_serial_shift.sv
// Purpose: shifts one conversion word out, master or slave clocked
// Assumes: load only while idle; the pin mux refuses loads while busy
// Notes: data moves on the falling serial clock, host samples on rising
`timescale 1ns/1ns
module aopmm_serial_shift (
  input  wire logic  clock,
  input  wire logic  rst_n,
  aopmm_ser_if.shift ser
);
  import aopmm_pkg::*;

  typedef enum logic [1:0] {AOPMM_SH_IDLE, AOPMM_SH_MASTER, AOPMM_SH_SLAVE} aopmm_sh_t;

  aopmm_sh_t   state_q;
  aopmm_word_t shift_q;
  logic [4:0]  bitCnt_q;
  logic [7:0]  divCnt_q;
  logic        sclk_q;
  logic        sclkPrev_q;
  logic        csPrev_q;
  logic [7:0]  halfLimit;
  logic        tick;
  logic        slaveFall;
  logic        slaveCut;
  logic        lastBit;

  assign halfLimit = 8'((SCLK_HALF_CYC << ser.divSel) - 1);
  assign tick      = (divCnt_q == halfLimit);
  assign slaveFall = sclkPrev_q & ~ser.sclkLvl & ser.csActive;
  assign slaveCut  = csPrev_q & ~ser.csActive;
  assign lastBit   = (bitCnt_q == 5'(RESULT_W - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b0;
    end else begin
      sclkPrev_q <= ser.sclkLvl;
      csPrev_q   <= ser.csActive;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= AOPMM_SH_IDLE;
      shift_q  <= RESULT_RST;
      bitCnt_q <= 5'h00;
      divCnt_q <= 8'h00;
      sclk_q   <= 1'b0;
    end else begin
      case (state_q)
        AOPMM_SH_IDLE: begin
          sclk_q   <= 1'b0;
          divCnt_q <= 8'h00;
          if (ser.loadStb) begin
            shift_q  <= ser.word;
            bitCnt_q <= 5'h00;
            state_q  <= ser.master ? AOPMM_SH_MASTER : AOPMM_SH_SLAVE;
          end
        end
        AOPMM_SH_MASTER: begin
          divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              shift_q  <= {shift_q[RESULT_W-2:0], 1'b0};
              bitCnt_q <= bitCnt_q + 5'h01;
              if (lastBit) begin
                state_q <= AOPMM_SH_IDLE;
              end
            end
          end
        end
        default: begin
          // slave: the host clock, gated by chip select, moves each bit
          if (slaveCut) begin
            // chip select lifted mid-frame: drop the rest, or every later load is refused
            shift_q <= RESULT_RST;
            state_q <= AOPMM_SH_IDLE;
          end else if (slaveFall) begin
            shift_q  <= {shift_q[RESULT_W-2:0], 1'b0};
            bitCnt_q <= bitCnt_q + 5'h01;
            if (lastBit) begin
              state_q <= AOPMM_SH_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign ser.sdOut   = shift_q[RESULT_W-1];
  assign ser.sclkDrv = sclk_q;
  assign ser.busy    = (state_q != AOPMM_SH_IDLE);

endmodule : aopmm_serial_shift

// ### aopmm_pin_mux.sv
// Purpose: selects the result output interface and the role of each shared data pin
// Assumes: mode and configuration pins come from outside and are synchronised here
// Notes: software loads each conversion word over Wishbone in place of a converter
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns

module aopmm_pin_mux (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [aopmm_pkg::ADR_W-1:0] adr_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  input  wire logic [3:0]              sel_i,
  input  wire logic                    we_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  output logic                         ack_o,
  input  wire logic [1:0]              modeIn,
  input  wire logic [aopmm_pkg::PIN_W-1:0] dataIn,
  output logic      [aopmm_pkg::PIN_W-1:0] dataOut,
  output logic      [aopmm_pkg::PIN_W-1:0] dataOe,
  input  wire logic                    readDuringConvertIn,
  input  wire logic                    chipSelectIn_n,
  input  wire logic                    sclkIn,
  output logic                         sclkOut,
  output logic                         sclkOe,
  output logic                         serialDataOut
);
  import aopmm_pkg::*;

  localparam int unsigned SYNC_W = 12;

  // synchronisers: stage one is read only by stage two
  logic [SYNC_W-1:0] pinSync1_q;
  logic [SYNC_W-1:0] pinSync2_q;

  aopmm_mode_t       mode;
  logic [PIN_W-1:0]  pinLvl;
  logic              readDuringConvertSelect;
  logic              csActive;
  logic              sclkLvl;

  logic              codingSelect;
  logic              formSelectLow;
  logic              formSelectHigh;
  logic [1:0]        serialClockDividerSelect;
  logic              clockSourceSelect;
  logic              isSerial;
  logic              isMaster;

  aopmm_word_t       result_q;
  logic              serEn_q;
  logic              overrun_q;
  logic              ack_q;
  logic [31:0]       rdData_q;
  logic              loadPend_q;
  logic [1:0]        divSel_q;

  aopmm_word_t       codedWord;
  aopmm_word_t       parWord;
  logic [PIN_W-1:0]  dataOut_d;
  logic [PIN_W-1:0]  dataOut_q;
  logic [PIN_W-1:0]  dataOe_d;
  logic [PIN_W-1:0]  dataOe_q;
  logic              serialData_q;
  logic              sclkOut_q;
  logic              sclkOe_q;

  logic              wbReq;
  logic              wbWrite;
  logic              hitResult;
  logic              hitStatus;
  logic              hitCtrl;
  logic [31:0]       status;
  logic [31:0]       mergedWord;

  aopmm_ser_if       ser ();

  // replace bytes of old with those of new whose lane is enabled
  function automatic logic [31:0] byteMerge(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  lanes);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        r[8*i +: 8] = newV[8*i +: 8];
      end
    end
    return r;
  endfunction : byteMerge

  // apply output coding; mode 0 never inverts
  function automatic aopmm_word_t applyCoding(input aopmm_mode_t m,
                                              input logic        straight,
                                              input aopmm_word_t w);
    aopmm_word_t r;
    r = w;
    if (m != AOPMM_MODE_P18 && !straight) begin
      r[RESULT_W-1] = ~w[RESULT_W-1];
    end
    return r;
  endfunction : applyCoding

  // place the chosen portion of the word on bits 6..0 of the pin group
  function automatic aopmm_word_t selectForm(input aopmm_mode_t m,
                                             input logic        hi,
                                             input logic        lo,
                                             input aopmm_word_t w);
    aopmm_word_t r;
    r = w;
    if (m == AOPMM_MODE_P16) begin
      case ({hi, lo})
        2'b00:   r = {2'b00, w[17:2]};
        2'b01:   r = {2'b00, w[1:0], 14'h0000};
        2'b10:   r = {2'b00, w[15:0]};
        default: r = {2'b00, w[9:2], w[17:10]};
      endcase
    end else if (m == AOPMM_MODE_P8) begin
      case ({hi, lo})
        2'b00:   r = {10'h000, w[17:10]};
        2'b01:   r = {10'h000, w[9:2]};
        2'b10:   r = {10'h000, w[1:0], 6'h00};
        default: r = 18'h00000;
      endcase
    end
    return r;
  endfunction : selectForm

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
    end else begin
      pinSync1_q <= {sclkIn, chipSelectIn_n, readDuringConvertIn, dataIn, modeIn};
      pinSync2_q <= pinSync1_q;
    end
  end

  assign mode                    = aopmm_mode_t'(pinSync2_q[1:0]);
  assign pinLvl                  = pinSync2_q[8:2];
  assign readDuringConvertSelect = pinSync2_q[9];
  assign csActive                = ~pinSync2_q[10];
  assign sclkLvl                 = pinSync2_q[11];

  assign isSerial          = (mode == AOPMM_MODE_SER);
  assign codingSelect      = pinLvl[0];
  assign formSelectLow     = pinLvl[1];
  assign formSelectHigh    = pinLvl[2];
  assign clockSourceSelect = isSerial & pinLvl[6];
  assign isMaster          = isSerial & ~clockSourceSelect;

  // the divider pins only count in master read-after-convert
  assign serialClockDividerSelect =
    (isMaster && !readDuringConvertSelect) ? pinLvl[5:4] : 2'b00;

  assign codedWord = applyCoding(mode, codingSelect, result_q);
  assign parWord   = selectForm(mode, formSelectHigh, formSelectLow, codedWord);

  always_comb begin
    dataOut_d = '0;
    dataOe_d  = '0;
    case (mode)
      AOPMM_MODE_P18: begin
        dataOut_d = parWord[6:0];
        dataOe_d  = 7'h7F;
      end
      AOPMM_MODE_P16, AOPMM_MODE_P8: begin
        // pins 0..2 are configuration inputs here
        dataOut_d = {parWord[6:3], 3'b000};
        dataOe_d  = 7'h78;
      end
      default: begin
        // serial: only pin 3 keeps driving; the divider pins float
        dataOut_d = 7'h00;
        dataOe_d  = 7'h08;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_q <= '0;
      dataOe_q  <= '0;
    end else begin
      dataOut_q <= dataOut_d;
      dataOe_q  <= dataOe_d;
    end
  end

  // Wishbone classic slave, one wait state; a write lands on the edge that sees
  // ack high, so it is taken only while the master still holds it
  assign wbReq   = cyc_i & stb_i & ~ack_q;
  assign wbWrite = cyc_i & stb_i & ack_q & we_i;

  // anything unmapped is acknowledged and reads zero
  always_comb begin
    hitResult = 1'b0;
    hitStatus = 1'b0;
    hitCtrl   = 1'b0;
    if (adr_i == RESULT_OFS) begin
      hitResult = 1'b1;
    end else if (adr_i == STATUS_OFS) begin
      hitStatus = 1'b1;
    end else if (adr_i == CTRL_OFS) begin
      hitCtrl = 1'b1;
    end
  end

  assign status = 32'({
    overrun_q,
    ser.busy,
    readDuringConvertSelect,
    clockSourceSelect,
    serialClockDividerSelect,
    formSelectHigh,
    formSelectLow,
    codingSelect,
    pinSync2_q[1:0]
  });

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wbReq;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 32'h00000000;
    end else begin
      if (wbReq && !we_i) begin
        if (hitResult) begin
          rdData_q <= 32'(result_q);
        end else if (hitStatus) begin
          rdData_q <= status;
        end else if (hitCtrl) begin
          rdData_q <= 32'(serEn_q);
        end else begin
          // unmapped: acknowledged, reads zero
          rdData_q <= 32'h00000000;
        end
      end
    end
  end

  assign mergedWord = byteMerge(32'(result_q), dat_i, sel_i);

  // a write while the shifter is busy keeps the old word and flags an overrun
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= RESULT_RST;
    end else if (wbWrite && hitResult && !ser.busy) begin
      result_q <= mergedWord[RESULT_W-1:0];
    end
  end

  // the shifter takes the word one cycle after it lands in the result register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadPend_q <= 1'b0;
    end else begin
      loadPend_q <= wbWrite & hitResult & ~ser.busy & isSerial & serEn_q;
    end
  end

  // the divider is frozen for a whole frame: a pin change in mid-frame must not
  // move the half-period limit under the running counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divSel_q <= 2'b00;
    end else if (!ser.busy) begin
      divSel_q <= serialClockDividerSelect;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serEn_q <= SER_EN_RST;
    end else if (wbWrite && hitCtrl && sel_i[0]) begin
      serEn_q <= dat_i[CTRL_SER_EN];
    end
  end

  // setting wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= OVERRUN_RST;
    end else if (wbWrite && hitResult && ser.busy) begin
      overrun_q <= 1'b1;
    end else if (wbWrite && hitCtrl && sel_i[0] && dat_i[CTRL_OVR_CLR]) begin
      overrun_q <= 1'b0;
    end
  end

  // coding is applied before the word enters the shifter
  assign ser.loadStb  = loadPend_q;
  assign ser.word     = codedWord;
  assign ser.master   = isMaster;
  assign ser.divSel   = divSel_q;
  assign ser.sclkLvl  = sclkLvl;
  assign ser.csActive = csActive;

  aopmm_serial_shift u_shift (
    .clock (clock),
    .rst_n (rst_n),
    .ser   (ser)
  );

  // serial data rests low outside serial mode so a parallel host sees no stray bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serialData_q <= 1'b0;
    end else begin
      serialData_q <= isSerial & ser.sdOut;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclkOut_q <= 1'b0;
      sclkOe_q  <= 1'b0;
    end else begin
      sclkOut_q <= isMaster & ser.sclkDrv;
      sclkOe_q  <= isMaster;
    end
  end

  assign dat_o         = rdData_q;
  assign ack_o         = ack_q;
  assign dataOut       = dataOut_q;
  assign dataOe        = dataOe_q;
  assign serialDataOut = serialData_q;
  assign sclkOut       = sclkOut_q;
  assign sclkOe        = sclkOe_q;

endmodule : aopmm_pin_mux

// ### aopmm_props.sv
// Purpose: port-level checks for the adc output port mode mux
// Assumes: pin levels held for six edges have passed the synchronisers
// Notes: bound to every pin mux instance
`timescale 1ns/1ns
module aopmm_props (
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic                        cyc_i,
  input wire logic                        stb_i,
  input wire logic                        ack_o,
  input wire logic [1:0]                  modeIn,
  input wire logic [aopmm_pkg::PIN_W-1:0] dataIn,
  input wire logic [aopmm_pkg::PIN_W-1:0] dataOut,
  input wire logic [aopmm_pkg::PIN_W-1:0] dataOe,
  input wire logic                        sclkOe,
  input wire logic                        serialDataOut
);
  import aopmm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // six steady edges: two sync stages, the pin register, and slack after reset
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged after one cycle");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_mode0_drive: assert property (
    (modeIn == 2'h0) [*6] |-> dataOe == 7'h7F) else $error("mode 0 pins not all driven");
  chk_par_upper: assert property (
    (modeIn != 2'h3) [*6] |-> &dataOe[6:3]) else $error("parallel upper pins not driven");
  chk_form_inputs: assert property (
    (modeIn inside {2'h1, 2'h2}) [*6] |-> dataOe[2:0] == 3'h0)
    else $error("select pins driven in narrow parallel mode");
  chk_ser_pins: assert property (
    (modeIn == 2'h3) [*6] |-> dataOe == 7'h08 && !dataOut[3])
    else $error("serial mode pin roles wrong");
  chk_master_clk: assert property (
    (modeIn == 2'h3 && !dataIn[6]) [*6] |-> sclkOe) else $error("master clock not driven");
  chk_slave_clk: assert property (
    (modeIn == 2'h3 && dataIn[6]) [*6] |-> !sclkOe) else $error("slave clock pin driven");
  chk_par_quiet: assert property (
    (modeIn != 2'h3) [*6] |-> !serialDataOut) else $error("serial data active in parallel");
endmodule : aopmm_props

bind aopmm_pin_mux aopmm_props chk (.clock(clock), .rst_n(rst_n), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .modeIn(modeIn), .dataIn(dataIn), .dataOut(dataOut),
  .dataOe(dataOe), .sclkOe(sclkOe), .serialDataOut(serialDataOut));

// ### aopmm_host_model.sv
// Purpose: host controller reading serial results
// Assumes: driven from the bench through its tasks only
// Notes: slave clock stands low between frames
`timescale 1ns/1ns
module aopmm_host_model (
  input  wire logic clock,
  input  wire logic sclkOut,
  input  wire logic serialDataOut,
  output logic      sclkIn,
  output logic      chipSelectIn_n
);
  initial begin
    sclkIn = 1'b0;
    chipSelectIn_n = 1'b1;
  end

  // samples on each rising device clock; half period from the first two rises
  task automatic master(output logic [17:0] w, output int half, output bit ok);
    int  n;
    int  n0;
    logic prev;
    n = 0;
    n0 = 0;
    ok = 1'b0;
    half = 0;
    w = 'x;
    for (int b = 17; b >= 0; b--) begin
      do begin
        prev = sclkOut;
        @(posedge clock);
        if (++n > 3000) return;
      end while (!(prev === 1'b0 && sclkOut === 1'b1));
      w[b] = serialDataOut;
      if (b == 17) n0 = n;
      if (b == 16) half = (n - n0) / 2;
    end
    ok = 1'b1;
  endtask : master

  // six system cycles per half period leave room for the device synchronisers
  task automatic slave(output logic [17:0] w);
    chipSelectIn_n <= 1'b0;
    repeat (6) @(posedge clock);
    for (int b = 17; b >= 0; b--) begin
      sclkIn <= 1'b1;
      w[b] = serialDataOut;
      repeat (6) @(posedge clock);
      sclkIn <= 1'b0;
      repeat (6) @(posedge clock);
    end
    chipSelectIn_n <= 1'b1;
  endtask : slave
endmodule : aopmm_host_model

// ### adc_output_port_mode_mux_bench.sv
// Purpose: self-checking bench for the adc output port mode mux
// Assumes: one ack per request, pins settle three edges after a change
// Notes: pin wires resolve from the device enables and the bench drivers
`timescale 1ns/1ns
module adc_output_port_mode_mux_bench;
  import aopmm_pkg::*;
  logic        clock, rst_n, we_i, cyc_i, stb_i, ack_o, rdc, csN, sclkIn, sclkOut, sclkOe, sdo;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [1:0]  modeIn;
  logic [6:0]  dataIn, dataOut, dataOe, pinDrv;
  logic [17:0] got;
  int          fails, num_checks, r, r2, e, half;
  bit          ok;

  assign dataIn = (dataOe & dataOut) | (~dataOe & pinDrv);
  aopmm_pin_mux dut (.clock(clock), .rst_n(rst_n), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .modeIn(modeIn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .readDuringConvertIn(rdc),
    .chipSelectIn_n(csN), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe),
    .serialDataOut(sdo));
  aopmm_host_model host (.clock(clock), .sclkOut(sclkOut), .serialDataOut(sdo),
    .sclkIn(sclkIn), .chipSelectIn_n(csN));
  always #25 clock = ~clock;

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clock);
      if (++n > 20) begin
        fails++;
        conclude();
      end
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  // expected {enables, outputs} from mode, form select, coding pin and result
  function automatic logic [13:0] expPins(int m, int a, int cod, int v);
    int w;
    if (m != 0 && cod == 0) v = v ^ 32'h20000;
    case (m)
      0: return {7'h7F, 7'(v)};
      1: w = a == 0 ? v >> 2 : a == 1 ? (v & 3) << 14 : a == 2 ? v
           : ((v >> 2) & 32'hFF) << 8 | (v >> 10) & 32'hFF;
      2: w = a == 0 ? v >> 10 : a == 1 ? v >> 2 : a == 2 ? (v & 3) << 6 : 0;
      default: return {7'h08, 7'h00};
    endcase
    return {7'h78, 7'(w) & 7'h78};
  endfunction : expPins

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, rdc} = '0;
    sel_i = 4'hF;
    modeIn = 2'h0;
    pinDrv = 7'h00;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'h403abbd7));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    wb(0, RESULT_OFS, 0);
    check("result reset", rd, 32'h0);
    wb(0, CTRL_OFS, 0);
    check("ctrl reset", rd, 32'h1);
    wb(1, 4'hC, 32'hFFFFFFFF);
    wb(0, 4'hC, 0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 8; p++) begin
        r = $urandom & 32'h3FFFF;
        modeIn <= 2'(m);
        pinDrv <= 7'($urandom) & 7'h78 | 7'(p);
        wb(1, RESULT_OFS, r);
        wb(0, RESULT_OFS, 0);
        check("result", rd, r);
        repeat (4) @(posedge clock);
        check("pins", {dataOe, dataOut}, expPins(m, p >> 1, p & 1, r));
      end
    end
    $display("test parallel done");
    modeIn <= 2'h3;
    repeat (4) @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      e = k[2] ? 0 : k & 3;
      r = $urandom & 32'h3FFFF;
      rdc <= k[2];
      pinDrv <= {1'b0, 2'(k), 1'b0, 3'($urandom)};
      repeat (4) @(posedge clock);
      wb(0, STATUS_OFS, 0);
      check("status", rd[8:0], {k[2], 1'b0, 2'(e), pinDrv[2:0], 2'h3});
      check("serial pins", {dataOe, dataOut}, expPins(3, 0, 0, 0));
      fork
        wb(1, RESULT_OFS, r);
        host.master(got, half, ok);
      join
      if (!ok) begin
        fails++;
        conclude();
      end
      check("master word", got, r ^ (pinDrv[0] ? 0 : 32'h20000));
      check("half period", half, 1 << e);
    end
    $display("test master done");
    rdc <= 1'b0;
    pinDrv <= 7'h31;
    r = $urandom & 32'h3FFFF;
    r2 = $urandom & 32'h3FFFF;
    repeat (4) @(posedge clock);
    fork
      begin
        wb(1, RESULT_OFS, r);
        wb(1, RESULT_OFS, r2);
        wb(0, STATUS_OFS, 0);
      end
      host.master(got, half, ok);
    join
    check("overrun set", rd[10], 1'b1);
    check("word kept", got, r);
    wb(1, CTRL_OFS, 32'h3);
    wb(0, STATUS_OFS, 0);
    check("overrun clear", rd[10], 1'b0);
    $display("test overrun done");
    pinDrv <= 7'h41;
    r = $urandom & 32'h3FFFF;
    repeat (4) @(posedge clock);
    check("slave clock pin", sclkOe, 1'b0);
    wb(1, RESULT_OFS, r);
    host.slave(got);
    check("slave word", got, r);
    wb(0, STATUS_OFS, 0);
    check("slave idle", rd[10:7], 4'h1);
    $display("test slave done");
    conclude();
  end
endmodule : adc_output_port_mode_mux_bench
